// ### hw/exec_unit.sv
// Executor for incrementing load, no-op, OR, pop and push instructions
`timescale 1ns/1ns
module exec_unit
  import ops_pkg::*;
#(
  parameter logic [7:0] WORK_BASE_P = WORK_BASE
) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire logic     start,
  input  wire instr_s   instr,
  input  wire logic [7:0] rf_rdata,
  input  wire logic [7:0] mem_rdata,
  output logic          ready,
  output rf_req_s       rf,
  output mem_req_s      mem,
  output flags_s        flags,
  output logic [7:0]    stack_pointer,
  output logic          done,
  output logic [1:0]    done_bytes,
  output logic          illegal
);

  // ---------------------------------------------------------------------
  // Working register mapping
  // ---------------------------------------------------------------------
  function automatic logic [7:0] wk(input logic [3:0] r);
    wk = {WORK_BASE_P[7:4], r};
  endfunction : wk

  typedef enum logic [10:0] {
    S_IDLE = 11'h001,
    S_PTR  = 11'h002,
    S_RDS  = 11'h004,
    S_RDD  = 11'h008,
    S_PTRD = 11'h010,
    S_PHI  = 11'h020,
    S_PLO  = 11'h040,
    S_MEM  = 11'h080,
    S_INCL = 11'h100,
    S_INCH = 11'h200,
    S_HOLD = 11'h400
  } state_e;

  // ---------------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------------
  wire logic [7:0] op = instr.opcode;
  wire logic [7:0] b1 = instr.byte1;
  wire logic [7:0] b2 = instr.byte2;
  wire logic is_or_w  = (op == OP_OR_RR) || (op == OP_OR_RIR);
  wire logic is_or_g  = (op == OP_OR_GG) || (op == OP_OR_GIR);
  wire logic is_or    = is_or_w || is_or_g || (op == OP_OR_GIM);
  wire logic is_pop   = (op == OP_POP_G) || (op == OP_POP_IND);
  wire logic is_push  = (op == OP_PUSH_G) || (op == OP_PUSH_IND);
  wire logic is_ldi   = (op == OP_LDI);
  wire logic is_nop   = (op == OP_NOP);
  wire logic d_known  = is_or || is_pop || is_push || is_ldi || is_nop;

  wire kind_e d_kind = is_or   ? K_OR   :
                       is_ldi  ? K_LDI  :
                       is_pop  ? K_POP  :
                       is_push ? K_PUSH : K_NOP;

  wire logic [3:0] d_cycles =
      is_ldi                 ? CYC_LDI   :
      (op == OP_OR_RR)       ? CYC_OR_RR :
      is_or                  ? CYC_OR_6  :
      (is_pop || is_push)    ? CYC_STACK : CYC_NOP;
  wire logic [3:0] d_last = d_cycles - 4'h1;

  wire logic [1:0] d_bytes =
      (is_or_g || op == OP_OR_GIM) ? BYTES_3 :
      (is_nop || !d_known)         ? BYTES_1 : BYTES_2;

  wire logic d_src_ind = (op == OP_OR_RIR) || (op == OP_OR_GIR)
                      || (op == OP_PUSH_IND);
  wire logic d_dst_ind = (op == OP_POP_IND);

  wire logic [7:0] d_dst = is_or_w                   ? wk(b1[7:4]) :
                           is_ldi                    ? wk(b1[7:4]) :
                           is_or_g                   ? b2          : b1;
  // The load names its pointer pair as a working register too
  wire logic [7:0] d_src = (is_or_w || is_ldi) ? wk(b1[3:0]) : b1;

  // Even register of the pair carries the high address byte
  wire logic [7:0] d_pair_hi = wk({b1[3:1], 1'b0});

  // ---------------------------------------------------------------------
  // Datapath state
  // ---------------------------------------------------------------------
  state_e      state;
  kind_e       kind;
  logic [3:0]  cyc;
  logic [3:0]  last;
  logic [1:0]  nbytes;
  logic        src_ind;
  logic        dst_ind;
  logic        space;
  logic [7:0]  dst_addr;
  logic [7:0]  src_addr;
  logic [7:0]  opa;
  logic [7:0]  ptr_hi;
  logic [7:0]  ptr_lo;

  wire logic [7:0] or_res  = opa | rf_rdata;
  wire logic [7:0] lo_inc  = ptr_lo + 8'h01;
  wire logic       lo_wrap = (ptr_lo == 8'hFF);
  wire logic [7:0] hi_next = ptr_hi + {7'h00, lo_wrap};
  wire logic [7:0] stk_dec = stack_pointer - 8'h01;
  wire logic [7:0] stk_inc = stack_pointer + 8'h01;
  wire logic       take    = ready && start;
  wire logic       at_last = (cyc == last);

  // ---------------------------------------------------------------------
  // Cycle counter keeps every instruction at its fixed length
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || state == S_IDLE) begin
      cyc <= 4'h0;
    end else begin
      cyc <= cyc + 4'h1;
    end
  end

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state         <= S_IDLE;
      kind          <= K_NOP;
      last          <= 4'h0;
      nbytes        <= 2'h0;
      src_ind       <= 1'b0;
      dst_ind       <= 1'b0;
      space         <= 1'b0;
      dst_addr      <= 8'h00;
      src_addr      <= 8'h00;
      opa           <= 8'h00;
      ptr_hi        <= 8'h00;
      ptr_lo        <= 8'h00;
      ready         <= 1'b1;
      rf            <= '0;
      mem           <= '0;
      flags         <= '0;
      stack_pointer <= STK_RESET;
      done          <= 1'b0;
      done_bytes    <= 2'h0;
      illegal       <= 1'b0;
    end else begin
      rf.rd   <= 1'b0;
      rf.wr   <= 1'b0;
      mem.rd  <= 1'b0;
      done    <= 1'b0;
      illegal <= 1'b0;
      case (state)
        S_IDLE: begin
          if (take) begin
            ready    <= 1'b0;
            kind     <= d_kind;
            last     <= d_last;
            nbytes   <= d_bytes;
            src_ind  <= d_src_ind;
            dst_ind  <= d_dst_ind;
            space    <= b1[0];
            dst_addr <= d_dst;
            src_addr <= d_src;
            illegal  <= !d_known;
            state    <= S_HOLD;
            if (is_ldi) begin
              rf.rd   <= 1'b1;
              rf.addr <= d_pair_hi;
              state   <= S_PHI;
            end else if (op == OP_OR_GIM) begin
              opa     <= b2;
              rf.rd   <= 1'b1;
              rf.addr <= d_dst;
              state   <= S_RDD;
            end else if (is_or || is_push) begin
              if (is_push) begin
                stack_pointer <= stk_dec;
              end
              rf.rd   <= 1'b1;
              rf.addr <= d_src;
              state   <= d_src_ind ? S_PTR : S_RDS;
            end else if (is_pop) begin
              rf.rd   <= 1'b1;
              rf.addr <= stack_pointer;
              state   <= S_RDS;
            end
          end
        end
        S_PTR: begin
          src_addr <= rf_rdata;
          rf.rd    <= 1'b1;
          rf.addr  <= rf_rdata;
          state    <= S_RDS;
        end
        S_RDS: begin
          opa <= rf_rdata;
          if (kind == K_PUSH) begin
            rf.wr    <= 1'b1;
            rf.addr  <= stack_pointer;
            rf.wdata <= rf_rdata;
            state    <= S_HOLD;
          end else if (kind == K_POP) begin
            stack_pointer <= stk_inc;
            if (dst_ind) begin
              rf.rd   <= 1'b1;
              rf.addr <= dst_addr;
              state   <= S_PTRD;
            end else begin
              rf.wr    <= 1'b1;
              rf.addr  <= dst_addr;
              rf.wdata <= rf_rdata;
              state    <= S_HOLD;
            end
          end else begin
            rf.rd   <= 1'b1;
            rf.addr <= dst_addr;
            state   <= S_RDD;
          end
        end
        S_RDD: begin
          // Only the destination is written back
          rf.wr    <= 1'b1;
          rf.addr  <= dst_addr;
          rf.wdata <= or_res;
          flags.z  <= (or_res == 8'h00);
          flags.s  <= or_res[7];
          flags.v  <= 1'b0;
          state    <= S_HOLD;
        end
        S_PTRD: begin
          rf.wr    <= 1'b1;
          rf.addr  <= rf_rdata;
          rf.wdata <= opa;
          state    <= S_HOLD;
        end
        S_PHI: begin
          ptr_hi  <= rf_rdata;
          rf.rd   <= 1'b1;
          rf.addr <= d_pair_lo(dst_addr, src_addr);
          state   <= S_PLO;
        end
        S_PLO: begin
          ptr_lo         <= rf_rdata;
          mem.rd         <= 1'b1;
          mem.data_space <= space;
          mem.addr       <= {ptr_hi, rf_rdata};
          state          <= S_MEM;
        end
        S_MEM: begin
          rf.wr    <= 1'b1;
          rf.addr  <= dst_addr;
          rf.wdata <= mem_rdata;
          state    <= S_INCL;
        end
        S_INCL: begin
          rf.wr    <= 1'b1;
          rf.addr  <= d_pair_lo(dst_addr, src_addr);
          rf.wdata <= lo_inc;
          state    <= S_INCH;
        end
        S_INCH: begin
          // Rewritten even without a carry; keeps the length fixed
          rf.wr    <= 1'b1;
          rf.addr  <= {src_addr[7:4], src_addr[3:1], 1'b0};
          rf.wdata <= hi_next;
          state    <= S_HOLD;
        end
        S_HOLD: begin
          // Flags stay put here for load, stack and no-op forms
          if (at_last) begin
            done       <= 1'b1;
            done_bytes <= nbytes;
            ready      <= 1'b1;
            state      <= S_IDLE;
          end
        end
        default: begin
          ready <= 1'b1;
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Odd register of the pair named by the source field
  function automatic logic [7:0] d_pair_lo(input logic [7:0] dsta,
                                           input logic [7:0] srca);
    d_pair_lo = {srca[7:4], srca[3:1], 1'b1} | (dsta & 8'h00);
  endfunction : d_pair_lo

endmodule : exec_unit

// ### hw/ops_pkg.sv
// Constants and carrier types for the load, OR, stack and no-op executor
// -----------------------------------------------------------------------
// How it works
// - Load byte via pointer pair, then bump pair
// - Same opcode, two bytes, ten cycles
// - Even pair field program, odd data memory
// - No-op changes nothing, one byte four cycles
// - Destination gets destination OR source
// - Source operand is never written
// - Zero flag on zero result, sign copies bit7
// - Overflow cleared; carry, decimal, half-carry kept
// - 44, 45, 46 are three-byte six-cycle forms
// - Pop reads at stack pointer, then increments
// - Pop and push keep every flag
// - Push decrements pointer first, then stores
// - Pointer pair even register holds high byte
// -----------------------------------------------------------------------
package ops_pkg;

  // ---------------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------------
  localparam logic [7:0] OP_LDI     = 8'hE3;
  localparam logic [7:0] OP_NOP     = 8'hFF;
  localparam logic [7:0] OP_OR_RR   = 8'h42;
  localparam logic [7:0] OP_OR_RIR  = 8'h43;
  localparam logic [7:0] OP_OR_GG   = 8'h44;
  localparam logic [7:0] OP_OR_GIR  = 8'h45;
  localparam logic [7:0] OP_OR_GIM  = 8'h46;
  localparam logic [7:0] OP_POP_G   = 8'h50;
  localparam logic [7:0] OP_POP_IND = 8'h51;
  localparam logic [7:0] OP_PUSH_G  = 8'h70;
  localparam logic [7:0] OP_PUSH_IND = 8'h71;

  // ---------------------------------------------------------------------
  // Cycle and byte counts
  // ---------------------------------------------------------------------
  localparam logic [3:0] CYC_LDI    = 4'hA;
  localparam logic [3:0] CYC_NOP    = 4'h4;
  localparam logic [3:0] CYC_OR_RR  = 4'h4;
  localparam logic [3:0] CYC_OR_6   = 4'h6;
  localparam logic [3:0] CYC_STACK  = 4'h8;
  localparam logic [1:0] BYTES_1    = 2'h1;
  localparam logic [1:0] BYTES_2    = 2'h2;
  localparam logic [1:0] BYTES_3    = 2'h3;

  // ---------------------------------------------------------------------
  // Reset value and working register base
  // ---------------------------------------------------------------------
  localparam logic [7:0] STK_RESET  = 8'h00;
  localparam logic [7:0] WORK_BASE  = 8'hC0;

  // ---------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } instr_s;

  typedef struct packed {
    logic       c;
    logic       z;
    logic       s;
    logic       v;
    logic       d;
    logic       h;
  } flags_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rf_req_s;

  typedef struct packed {
    logic        rd;
    logic        data_space;
    logic [15:0] addr;
  } mem_req_s;

  typedef enum logic [2:0] {
    K_NOP  = 3'h0,
    K_OR   = 3'h1,
    K_LDI  = 3'h2,
    K_POP  = 3'h3,
    K_PUSH = 3'h4
  } kind_e;

endpackage : ops_pkg

// ### testbench/exec_unit_properties.sv
// Concurrent port checks for the executor, bound onto exec_unit
`timescale 1ns/1ns
module exec_unit_properties
  import ops_pkg::*;
#(
  parameter logic [7:0] WORK_BASE_P = WORK_BASE
) (
  input logic       clk,
  input logic       rst_n,
  input logic       start,
  input instr_s     instr,
  input logic [7:0] rf_rdata,
  input logic [7:0] mem_rdata,
  input logic       ready,
  input rf_req_s    rf,
  input mem_req_s   mem,
  input flags_s     flags,
  input logic [7:0] stack_pointer,
  input logic       done,
  input logic [1:0] done_bytes,
  input logic       illegal
);
  // ----------------------------------------------------------------
  // Snapshot of the instruction in flight
  // ----------------------------------------------------------------
  logic [7:0] op_q;
  logic [7:0] b1_q;
  logic [7:0] stk_q;
  flags_s     fl_q;
  wire        take   = ready && start;
  wire        is_or  = op_q inside {[OP_OR_RR:OP_OR_GIM]};
  wire        is_stk = op_q inside {OP_POP_G, OP_POP_IND, OP_PUSH_G,
                                    OP_PUSH_IND};
  wire        is_stk_op = instr.opcode inside {OP_POP_G, OP_POP_IND,
                                               OP_PUSH_G, OP_PUSH_IND};
  wire        three  = op_q inside {OP_OR_GG, OP_OR_GIR, OP_OR_GIM};
  wire        two    = is_or || is_stk || op_q == OP_LDI;
  wire  [1:0] exp_nb = three ? BYTES_3 : two ? BYTES_2 : BYTES_1;
  always_ff @(posedge clk) begin
    if (take) begin
      op_q <= instr.opcode;
      b1_q <= instr.byte1;
      stk_q <= stack_pointer;
      fl_q <= flags;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence nop_wait; (!done && !ready)[*4] ##1 (done && ready); endsequence
  sequence ldi_wait; !done[*8] ##1 !done[*2] ##1 done; endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_nop_timing: assert property (take && instr.opcode == OP_NOP |=> nop_wait)
    else $error("no-op length wrong");
  a_load_timing: assert property (take && instr.opcode == OP_LDI |=> ldi_wait)
    else $error("load length wrong");
  a_stack_timing: assert property (take && is_stk_op
    |=> !done[*8] ##1 done) else $error("stack length wrong");
  a_or_short: assert property (take && instr.opcode == OP_OR_RR
    |=> !done[*4] ##1 done) else $error("short OR length wrong");
  a_or_long: assert property (take && instr.opcode inside {[8'h43:8'h46]}
    |=> !done[*6] ##1 done) else $error("long OR length wrong");
  a_done_bytes: assert property (done |-> done_bytes == exp_nb)
    else $error("byte count wrong");
  a_space_select: assert property (mem.rd |-> mem.data_space == b1_q[0])
    else $error("memory space wrong");
  a_stack_move: assert property (done && is_stk |-> stack_pointer ==
    (op_q[5] ? stk_q - 8'h01 : stk_q + 8'h01))
    else $error("stack pointer wrong");
  a_or_flags: assert property (done && is_or |-> flags.z == (rf.wdata == 8'h00)
    && flags.s == rf.wdata[7] && !flags.v) else $error("OR flags wrong");
  a_flags_kept: assert property (done && !is_or |-> flags == fl_q)
    else $error("flags disturbed");
endmodule : exec_unit_properties

bind exec_unit exec_unit_properties #(.WORK_BASE_P(WORK_BASE_P))
  i_exec_unit_properties (.clk(clk), .rst_n(rst_n), .start(start),
  .instr(instr), .rf_rdata(rf_rdata), .mem_rdata(mem_rdata), .ready(ready),
  .rf(rf), .mem(mem), .flags(flags), .stack_pointer(stack_pointer),
  .done(done), .done_bytes(done_bytes), .illegal(illegal));

// ### testbench/rf_mem_model.sv
// Register file and memory stand-in behind the executor
`timescale 1ns/1ns
module rf_mem_model
  import ops_pkg::*;
(
  input  logic       clk,
  input  rf_req_s    rf,
  input  mem_req_s   mem,
  output logic [7:0] rf_rdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] regs [256];
  logic [7:0] junk;
  wire  [7:0] mem_val = mem.addr[15:8] ^ mem.addr[7:0] ^
                        (mem.data_space ? 8'h5A : 8'hA5);
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    junk = 8'h00;
  end
  // Data answers the registered request within its own cycle; outside a
  // read it flips every cycle so a mistimed sample never matches
  assign rf_rdata  = rf.rd ? regs[rf.addr] : ~junk;
  assign mem_rdata = mem.rd ? mem_val : junk;
  always @(posedge clk) begin
    if (rf.wr) regs[rf.addr] <= rf.wdata;
    junk <= ~junk;
  end
endmodule : rf_mem_model

// ### testbench/tb_top.sv
// Self-checking bench for the executor
`timescale 1ns/1ns
module tb_top;
  import ops_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [3:0] cyc;
    logic [3:0] nb;
    logic [7:0] a1;
    logic [7:0] v1;
    logic [7:0] a2;
    logic [7:0] v2;
    logic [7:0] fl;
    logic [7:0] stk;
  } row_s;
  logic       clk;
  logic       rst_n;
  logic       start;
  instr_s     instr;
  logic [7:0] rf_rdata;
  logic [7:0] mem_rdata;
  logic       ready;
  rf_req_s    rf;
  mem_req_s   mem;
  flags_s     flags;
  logic [7:0] stack_pointer;
  logic       done;
  logic [1:0] done_bytes;
  logic       illegal;
  int         fails;
  int         n_compared;
  int         n;
  logic [15:0] pre [14] = '{16'hC015, 16'hC12A, 16'hC201, 16'h0137,
    16'h0008, 16'h088A, 16'h404F, 16'h4142, 16'h42AA, 16'h4445, 16'hC610,
    16'hC733, 16'hC412, 16'hC5FF};
  // Rows run in order: each leaves the state the next one expects
  row_s rows [14] = '{
    80'h430200_62_C037C201_0000, 80'h420100_42_C03FC12A_0000,
    80'h450001_63_01BF088A_0800, 80'h440100_63_00BF01BF_0800,
    80'h461000_63_1000C03F_1000, 80'hFF0000_41_1000C03F_1000,
    80'h704000_82_FF4F404F_10FF, 80'h714100_82_FEAA4142_10FE,
    80'h504300_82_43AAFEAA_10FF, 80'h514400_82_454F4445_1000,
    80'hE38600_A2_C886C734_1000, 80'hE38700_A2_C87EC735_1000,
    80'hE38400_A2_C848C413_1000, 80'h000000_41_C03FC500_1000};
  exec_unit i_exec_unit (.clk(clk), .rst_n(rst_n), .start(start),
    .instr(instr), .rf_rdata(rf_rdata), .mem_rdata(mem_rdata),
    .ready(ready), .rf(rf), .mem(mem), .flags(flags),
    .stack_pointer(stack_pointer), .done(done), .done_bytes(done_bytes),
    .illegal(illegal));
  rf_mem_model i_rf_mem_model (.clk(clk), .rf(rf), .mem(mem),
    .rf_rdata(rf_rdata), .mem_rdata(mem_rdata));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_idle;
    chk({12'h0, ready, done, flags == 6'h00, 1'b0}, 16'h000A, "idle");
    chk({8'h0, stack_pointer}, {8'h0, STK_RESET}, "idle stack");
  endtask : chk_idle
  task automatic run(input row_s r);
    logic ill;
    @(posedge clk);
    start <= 1'b1;
    instr <= {r.op, r.b1, r.b2};
    @(posedge clk);
    start <= 1'b0;
    #1;
    ill = illegal;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      #1;
    end while (done !== 1'b1 && n < 20);
    chk(16'(n), {12'h0, r.cyc}, "cycles");
    chk({14'h0, done_bytes}, {12'h0, r.nb}, "bytes");
    chk({8'h0, i_rf_mem_model.regs[r.a1]}, {8'h0, r.v1}, "dst");
    chk({8'h0, i_rf_mem_model.regs[r.a2]}, {8'h0, r.v2}, "aux");
    chk({10'h0, flags}, {8'h0, r.fl}, "flags");
    chk({8'h0, stack_pointer}, {8'h0, r.stk}, "stack");
    chk(16'(ill), 16'(r.nb == 4'h1 && r.op != OP_NOP), "illegal");
  endtask : run
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    instr = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (pre[i]) i_rf_mem_model.regs[pre[i][15:8]] = pre[i][7:0];
    #1;
    chk_idle();
    foreach (rows[i]) run(rows[i]);
    // Start held high: the second no-op is taken as soon as ready returns
    @(posedge clk);
    start <= 1'b1;
    instr <= {OP_NOP, 16'h0000};
    @(posedge clk);
    n = 0;
    repeat (9) begin
      @(posedge clk);
      #1;
      n += int'(done);
    end
    chk(16'(n), 16'h0002, "back to back");
    chk({15'h0, done}, 16'h0001, "second done");
    @(posedge clk);
    start <= 1'b0;
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_idle();
    end_sim();
  end
endmodule : tb_top
